// >>> hdl/osl_defs.svh
// constants for the orientation status logic: offsets, fields, resets
// assumes an 8-bit register port with one-cycle read and write strobes
`ifndef OSL_DEFS_SVH
`define OSL_DEFS_SVH
`define OSL_STATUS_ADDR 8'h10
`define OSL_CONFIG_ADDR 8'h11
`define OSL_ST_CHANGE_BIT 7
`define OSL_ST_LOCK_BIT 6
`define OSL_ST_CODE_HI 2
`define OSL_ST_CODE_LO 1
`define OSL_ST_BF_BIT 0
`define OSL_CFG_MODE_BIT 7
`define OSL_CFG_EN_BIT 6
`define OSL_MODE_RESET 1'b1
`define OSL_EN_RESET 1'b0
`define OSL_CODE_RESET 2'h0
`define OSL_LIMIT_DEFAULT 16'h0a00
`define OSL_DBNC_DEFAULT 8'h00
`endif

// >>> hdl/osl_orientation_status.sv
// orientation status and configuration registers with debounce and hold
// assumes one sample-valid pulse per new raw orientation result
//
// Summary of operation
// - change flag sets on first result after activation or any field change.
// - a status register read clears the change flag, unless a new result is taken in the same cycle.
// - a status read also clears the orientation interrupt source.
// - the fields keep updating while the change flag is set.
// - the result is held while any axis magnitude exceeds 1.25g.
// - lockout flag is one past the tilt lockout angle, zero otherwise.
// - code 00 portrait up, 01 down, 10 landscape right, 11 landscape left.
// - back/front flag is zero for front and one for back.
// - fields reset to zero.
// - status bit 7 change, 6 lockout, 2:1 code, 0 back/front, 5:3 zero.
// - config bit 7 debounce mode, bit 6 enable, bits 5:0 zero.
// - debounce mode zero decrements, one clears, reset value one.
// - the enable resets to zero and writing one enables detection.
// - a wake/sleep transition resets the debounce counter.
// - the interrupt source is set while change flag and irq enable are set.
`timescale 1ns/1ps
`default_nettype none
`include "osl_defs.svh"
module osl_orientation_status
  import osl_pkg::*;
#(
  parameter int AXIS_W = 12,
  parameter logic [AXIS_W-1:0] LIMIT_MAG = AXIS_W'(`OSL_LIMIT_DEFAULT),
  parameter int CNT_W = 8
)
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic sample_valid_in,
  input wire osl_result_s raw_result_in,
  input wire logic [AXIS_W-1:0] abs_x_in,
  input wire logic [AXIS_W-1:0] abs_y_in,
  input wire logic [AXIS_W-1:0] abs_z_in,
  input wire logic active_in,
  input wire logic sleep_in,
  input wire logic irq_enable_in,
  input wire logic [CNT_W-1:0] debounce_count_in,
  output osl_result_s result_out,
  output logic orient_change_flag_out,
  output logic orient_irq_source_out,
  output logic orient_detect_enable_out,
  output logic debounce_mode_sel_out
);
  initial
  begin
    if (AXIS_W < 2 || CNT_W < 1)
      $error("osl: width parameters too small");
  end

  function automatic logic [7:0] status_word(input logic chg,
                                             input osl_result_s r);
    logic [7:0] w;
    w = 8'h00;
    w[`OSL_ST_CHANGE_BIT] = chg;
    w[`OSL_ST_LOCK_BIT] = r.lockout;
    w[`OSL_ST_CODE_HI:`OSL_ST_CODE_LO] = r.code;
    w[`OSL_ST_BF_BIT] = r.back;
    return w;
  endfunction

  osl_cfg_s cfg_reg, cfg_next;
  osl_result_s result_reg, result_next;
  logic change_reg, change_next;
  logic irq_reg, irq_next;
  logic first_reg, first_next;
  logic active_reg, active_next;
  logic sleep_reg, sleep_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [7:0] rdata_reg, rdata_next;
  logic status_rd, over_limit, differs, settled, take;

  always_comb
  begin
    status_rd = reg_rd_in && (reg_addr_in == `OSL_STATUS_ADDR);
    over_limit = (abs_x_in > LIMIT_MAG) || (abs_y_in > LIMIT_MAG)
                 || (abs_z_in > LIMIT_MAG);
    differs = (raw_result_in != result_reg);
    settled = (cnt_reg >= debounce_count_in);
    cfg_next = cfg_reg;
    if (reg_wr_in && reg_addr_in == `OSL_CONFIG_ADDR)
    begin
      cfg_next.debounce_mode_sel = reg_wdata_in[`OSL_CFG_MODE_BIT];
      cfg_next.orient_detect_enable = reg_wdata_in[`OSL_CFG_EN_BIT];
    end
    cnt_next = cnt_reg;
    take = 1'b0;
    active_next = active_in;
    sleep_next = sleep_in;
    if (sleep_in != sleep_reg)
      cnt_next = '0;
    else if (sample_valid_in && cfg_reg.orient_detect_enable
             && active_in && !over_limit)
    begin
      if (differs || first_reg)
      begin
        if (settled || first_reg)
        begin
          take = 1'b1;
          cnt_next = '0;
        end
        else
          cnt_next = CNT_W'(cnt_reg + 1'b1);
      end
      else if (cfg_reg.debounce_mode_sel)
        cnt_next = '0;
      else if (cnt_reg != '0)
        cnt_next = CNT_W'(cnt_reg - 1'b1);
    end
    first_next = first_reg;
    if (active_in && !active_reg)
      first_next = 1'b1;
    else if (take)
      first_next = 1'b0;
    result_next = result_reg;
    if (take)
      result_next = raw_result_in;
    change_next = change_reg;
    if (take && (differs || first_reg))
      change_next = 1'b1;
    else if (status_rd)
      change_next = 1'b0;
    irq_next = change_next && irq_enable_in;
    rdata_next = 8'h00;
    if (reg_rd_in && reg_addr_in == `OSL_STATUS_ADDR)
      rdata_next = status_word(change_reg, result_reg);
    else if (reg_rd_in && reg_addr_in == `OSL_CONFIG_ADDR)
    begin
      rdata_next[`OSL_CFG_MODE_BIT] = cfg_reg.debounce_mode_sel;
      rdata_next[`OSL_CFG_EN_BIT] = cfg_reg.orient_detect_enable;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cfg_reg <= '{`OSL_MODE_RESET, `OSL_EN_RESET};
      result_reg <= '0;
      change_reg <= 1'b0;
      irq_reg <= 1'b0;
      first_reg <= 1'b0;
      active_reg <= 1'b0;
      sleep_reg <= 1'b0;
      cnt_reg <= '0;
      rdata_reg <= 8'h00;
    end
    else
    begin
      cfg_reg <= cfg_next;
      result_reg <= result_next;
      change_reg <= change_next;
      irq_reg <= irq_next;
      first_reg <= first_next;
      active_reg <= active_next;
      sleep_reg <= sleep_next;
      cnt_reg <= cnt_next;
      rdata_reg <= rdata_next;
    end
  end

  always_comb
  begin
    reg_rdata_out = rdata_reg;
    result_out = result_reg;
    orient_change_flag_out = change_reg;
    orient_irq_source_out = irq_reg;
    orient_detect_enable_out = cfg_reg.orient_detect_enable;
    debounce_mode_sel_out = cfg_reg.debounce_mode_sel;
  end

  property p_read_clears;
    @(posedge clk_in) disable iff (!rst_n_in)
    (status_rd && !take) |=> !orient_change_flag_out;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("read kept flag");

  property p_change_sets;
    @(posedge clk_in) disable iff (!rst_n_in)
    (take && differs) |=> orient_change_flag_out
      && result_out == $past(raw_result_in);
  endproperty
  a_change_sets: assert property (p_change_sets)
    else $error("change lost");

  property p_irq_follows;
    @(posedge clk_in) disable iff (!rst_n_in)
    1'b1 |=> orient_irq_source_out ==
      ($past(irq_enable_in) && orient_change_flag_out);
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("irq wrong");

  property p_irq_read;
    @(posedge clk_in) disable iff (!rst_n_in)
    (status_rd && !take) |=> !orient_irq_source_out;
  endproperty
  a_irq_read: assert property (p_irq_read)
    else $error("irq kept");

  property p_hold_high_g;
    @(posedge clk_in) disable iff (!rst_n_in)
    over_limit |=> $stable(result_out);
  endproperty
  a_hold_high_g: assert property (p_hold_high_g)
    else $error("moved at high g");

  property p_hold_disabled;
    @(posedge clk_in) disable iff (!rst_n_in)
    !orient_detect_enable_out |=> $stable(result_out)
      && !$rose(orient_change_flag_out);
  endproperty
  a_hold_disabled: assert property (p_hold_disabled)
    else $error("moved disabled");

  property p_status_map;
    @(posedge clk_in) disable iff (!rst_n_in)
    status_rd |=> reg_rdata_out == {$past(change_reg),
      $past(result_reg.lockout), 3'h0, $past(result_reg.code),
      $past(result_reg.back)};
  endproperty
  a_status_map: assert property (p_status_map)
    else $error("status map");

  property p_cfg_write;
    @(posedge clk_in) disable iff (!rst_n_in)
    (reg_wr_in && reg_addr_in == `OSL_CONFIG_ADDR) |=>
      orient_detect_enable_out == $past(reg_wdata_in[`OSL_CFG_EN_BIT])
      && debounce_mode_sel_out == $past(reg_wdata_in[`OSL_CFG_MODE_BIT]);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("cfg write");

  property p_sleep_clear;
    @(posedge clk_in) disable iff (!rst_n_in)
    (sleep_in != sleep_reg) |=> cnt_reg == '0;
  endproperty
  a_sleep_clear: assert property (p_sleep_clear)
    else $error("count kept");

  c_change: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(orient_change_flag_out));
  c_read: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    orient_change_flag_out && status_rd);
  c_hold: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    over_limit && sample_valid_in && differs);
endmodule
`default_nettype wire

// >>> hdl/osl_pkg.sv
// types shared by the orientation status logic
// assumes osl_defs.svh for numeric constants
`default_nettype none
package osl_pkg;
  typedef enum logic [1:0] {
    OSL_PORTRAIT_UP = 2'h0,
    OSL_PORTRAIT_DOWN = 2'h1,
    OSL_LANDSCAPE_RIGHT = 2'h2,
    OSL_LANDSCAPE_LEFT = 2'h3
  } osl_code_e;
  typedef struct packed {
    logic lockout;
    osl_code_e code;
    logic back;
  } osl_result_s;
  typedef struct packed {
    logic debounce_mode_sel;
    logic orient_detect_enable;
  } osl_cfg_s;
endpackage
`default_nettype wire

// >>> testbench/orientation_status_logic_tb_top.sv
// bench for the orientation status logic: register and sample tests
// assumes osl_host_model for register access
`timescale 1ns/1ps
`default_nettype none
module orientation_status_logic_tb_top;
  import osl_pkg::*;
  localparam logic [11:0] LIM = 12'ha00;
  logic clk, rst_n, sv, act, slp, irq_en, rd, wr, chg, irq, en, mode;
  logic [7:0] addr, wdata, rdata, dbc;
  logic [11:0] ax, ay, az;
  logic [3:0] tbl [4] = '{4'h1, 4'h2, 4'h5, 4'hf};
  osl_result_s raw, res;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  osl_orientation_status #(.LIMIT_MAG(LIM)) osl_orientation_status_inst (
    .clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_rd_in(rd),
    .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .sample_valid_in(sv), .raw_result_in(raw), .abs_x_in(ax),
    .abs_y_in(ay), .abs_z_in(az), .active_in(act),
    .sleep_in(slp), .irq_enable_in(irq_en), .debounce_count_in(dbc),
    .result_out(res), .orient_change_flag_out(chg),
    .orient_irq_source_out(irq), .orient_detect_enable_out(en),
    .debounce_mode_sel_out(mode));
  osl_host_model osl_host_model_inst (.clk_in(clk), .reg_addr_out(addr),
    .reg_rd_out(rd), .reg_wr_out(wr), .reg_wdata_out(wdata),
    .reg_rdata_in(rdata));
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rc(input logic [7:0] a, e, input string nm);
    logic [7:0] d;
    osl_host_model_inst.rd(a, d);
    chk(nm, e, d);
  endtask
  task automatic smp(input logic [3:0] r, input logic [11:0] a);
    @(negedge clk);
    raw = osl_result_s'(r);
    ax = a;
    sv = 1'b1;
    @(negedge clk);
    sv = 1'b0;
    ax = 12'h000;
  endtask
  // differing, differing, equal, differing, differing samples
  task automatic dbs();
    smp(4'h2, 12'h000);
    smp(4'h2, 12'h000);
    smp(4'h9, 12'h000);
    smp(4'h2, 12'h000);
    smp(4'h2, 12'h000);
  endtask
  function automatic logic [7:0] st(input logic c, input logic [3:0] r);
    return {c, r[3], 3'b000, r[2:0]};
  endfunction
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_errors++;
      end_of_test();
    end
  end
  initial
  begin
    {rst_n, sv, act, slp, irq_en, ax, ay, az, dbc} = '0;
    raw = osl_result_s'(4'h0);
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    rc(8'h10, 8'h00, "status reset");
    rc(8'h11, 8'h80, "config reset");
    chk("mode out", 8'h01, {7'h00, mode});
    osl_host_model_inst.wr(8'h11, 8'hff);
    rc(8'h11, 8'hc0, "config rw");
    chk("enable out", 8'h01, {7'h00, en});
    osl_host_model_inst.wr(8'h10, 8'hff);
    rc(8'h10, 8'h00, "status ro");
    rc(8'h20, 8'h00, "unmapped");
    $display("register test done");
    irq_en = 1'b1;
    act = 1'b1;
    smp(4'h0, 12'h000);
    chk("irq set", 8'h01, {7'h00, irq});
    rc(8'h10, st(1'b1, 4'h0), "first result");
    chk("irq clear", 8'h00, {7'h00, irq});
    for (int i = 0; i < 4; i++)
    begin
      smp(tbl[i], LIM);
      rc(8'h10, st(1'b1, tbl[i]), "code");
      rc(8'h10, st(1'b0, tbl[i]), "read clear");
    end
    $display("code test done");
    smp(4'h2, 12'h000);
    smp(4'h4, 12'h000);
    rc(8'h10, st(1'b1, 4'h4), "keeps updating");
    smp(4'h6, LIM + 12'h001);
    rc(8'h10, st(1'b0, 4'h4), "over limit hold");
    ay = LIM + 12'h001;
    smp(4'h6, 12'h000);
    ay = 12'h000;
    az = LIM + 12'h001;
    smp(4'h6, 12'h000);
    az = 12'h000;
    rc(8'h10, st(1'b0, 4'h4), "y z over limit");
    irq_en = 1'b0;
    smp(4'h9, 12'h000);
    chk("irq masked", 8'h00, {7'h00, irq});
    rc(8'h10, st(1'b1, 4'h9), "lockout");
    slp = 1'b1;
    osl_host_model_inst.wr(8'h11, 8'h80);
    smp(4'h6, 12'h000);
    rc(8'h10, st(1'b0, 4'h9), "disabled hold");
    $display("sample test done");
    dbc = 8'h02;
    osl_host_model_inst.wr(8'h11, 8'hc0);
    dbs();
    rc(8'h10, st(1'b0, 4'h9), "clear mode");
    slp = 1'b0;
    smp(4'h2, 12'h000);
    rc(8'h10, st(1'b0, 4'h9), "sleep clears count");
    slp = 1'b1;
    osl_host_model_inst.wr(8'h11, 8'h40);
    dbs();
    rc(8'h10, st(1'b1, 4'h2), "decrement mode");
    act = 1'b0;
    @(negedge clk);
    act = 1'b1;
    smp(4'h2, 12'h000);
    rc(8'h10, st(1'b1, 4'h2), "reactivate");
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rc(8'h10, 8'h00, "status after reset");
    rc(8'h11, 8'h80, "config after reset");
    $display("debounce test done");
    end_of_test();
  end
endmodule
`default_nettype wire

// >>> testbench/osl_host_model.sv
// host controller model: drives the register strobes of the block
// assumes clk_in from the bench; drives on the falling edge
`timescale 1ns/1ps
`default_nettype none
module osl_host_model
(
  input wire logic clk_in,
  output logic [7:0] reg_addr_out,
  output logic reg_rd_out,
  output logic reg_wr_out,
  output logic [7:0] reg_wdata_out,
  input wire logic [7:0] reg_rdata_in
);
  initial
  begin
    reg_addr_out = 8'h00;
    reg_rd_out = 1'b0;
    reg_wr_out = 1'b0;
    reg_wdata_out = 8'h00;
  end
  // one-cycle write strobe, data dropped after the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(negedge clk_in);
    reg_wr_out = 1'b0;
    reg_wdata_out = ~d;
    reg_addr_out = ~a;
  endtask
  // read data is registered on the taking edge and picked up half a cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_in);
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(negedge clk_in);
    d = reg_rdata_in;
    reg_rd_out = 1'b0;
    reg_addr_out = ~a;
  endtask
endmodule
`default_nettype wire
